/* File: verilog/swep_pkg.sv */
// shared constants of the serial word memory protocol
package swep_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int          HDR_BITS   = 8;
    localparam int          ADDR_BITS  = 8;
    localparam int          DATA_BITS  = 16;
    localparam int          MEM_WORDS  = 256;
    localparam logic [5:0]  CNT_HDR    = 6'h07;
    localparam logic [5:0]  CNT_ADDR   = 6'h0f;
    localparam logic [5:0]  CNT_DATA   = 6'h1f;
    // start pattern and opcodes, in time order
    localparam logic [3:0]  START_PAT  = 4'ha;
    localparam logic [3:0]  OP_READ    = 4'h8;
    localparam logic [3:0]  OP_WRITE   = 4'h4;
    localparam logic [3:0]  OP_UNLOCK  = 4'h3;
    localparam logic [3:0]  OP_LOCK    = 4'h0;
    localparam logic [15:0] ERASED     = 16'hffff;
    // synchroniser reset: select idles high, the other pins low
    localparam logic [3:0]  PIN_IDLE   = 4'h8;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_NS     = 25;
    localparam int          STATUS_NS  = 150;
    localparam int          STATUS_CYC = STATUS_NS / CLK_NS;
    localparam int          PROG_MS    = 10;
    localparam int          PROG_CYC   = PROG_MS * 1000000 / CLK_NS;

    typedef enum logic [2:0] {
        ST_FRAME  = 3'b000,
        ST_READ   = 3'b001,
        ST_WRITE  = 3'b010,
        ST_IGNORE = 3'b011,
        ST_BUSY   = 3'b100
    } swep_state_e;
endpackage : swep_pkg

/* File: verilog/swep_sync.sv */
// two-flop synchroniser for the pin inputs
module swep_sync #(
    parameter int           W    = 4,
    // reset level per bit, so each output starts at its pin's idle level
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= INIT;
            synced <= INIT;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule : swep_sync

/* File: verilog/swep_core.sv */
// device side of the serial word memory: framing, array, programming
//
// Behaviour
// - power-up starts write-locked
// - writes need prior unlock; lock relocks
// - clocks past sixteenth ignored on lock/unlock
// - lock/unlock ignore the write-guard pin
// - lock/unlock act at sixteenth rising edge
// - read data starts at sixteenth falling edge
// - next word every sixteen further clocks
// - raising select ends a read
// - guard high while programming halts programming
// - after ready, ignore input until select rises
// - busy low status delay after 32nd edge
// - self-timed programming starts at last bit
// - select fall, clock low: status on output
// - no instructions accepted while busy
// - select or guard pulse cancels pending write
// - select high while ready resets interface
// - select high cancels read, lock, unlock
// - active only while select is low
// - address and data travel LSB first
// - input sampled on serial clock rising edge
// - output changes on serial clock falling edge; the status bit follows ready/busy at once, without a clock edge
module swep_core #(
    parameter int PROG_CYCLES = swep_pkg::PROG_CYC
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic selectN,
    input  wire logic serial_clock_in,
    input  wire logic serial_in,
    input  wire logic write_guard_pin,
    output logic      serialOut,
    output logic      serialOutOe,
    output logic      readyBusyN
);
    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    logic [3:0] pinS;
    logic       selS, skS, sinS, guardS;
    logic       selPrev_q, skPrev_q;
    logic       skRise, skFall, csRise, csFall;

    // a low select reset value would fake a select fall after reset
    swep_sync #(.W(4), .INIT(swep_pkg::PIN_IDLE)) u_sync (
        .mclk   (mclk),
        .reset  (reset),
        .async  ({selectN, serial_clock_in, serial_in, write_guard_pin}),
        .synced (pinS)
    );

    assign {selS, skS, sinS, guardS} = pinS;
    // selection counts as high through reset so no frame starts early
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            selPrev_q <= 1'b1;
            skPrev_q  <= 1'b0;
        end else begin
            selPrev_q <= selS;
            skPrev_q  <= skS;
        end
    end

    assign skRise = skS & ~skPrev_q & ~selS;
    assign skFall = ~skS & skPrev_q & ~selS;
    assign csRise = selS & ~selPrev_q;
    assign csFall = ~selS & selPrev_q;

    // ------------------------------------------------------------
    // word array, erased at reset
    // ------------------------------------------------------------
    logic [15:0] mem [swep_pkg::MEM_WORDS];
    logic        memWe;
    logic [7:0]  addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < swep_pkg::MEM_WORDS; i++) begin
                mem[i] <= swep_pkg::ERASED;
            end
        end else if (memWe) begin
            mem[addr_q] <= wdata_q;
        end
    end

    // ------------------------------------------------------------
    // protocol state
    // ------------------------------------------------------------
    swep_pkg::swep_state_e state_q, state_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [7:0]  hdr_q, hdr_d;
    logic [3:0]  rdPtr_q, rdPtr_d;
    logic        unlocked_q, unlocked_d;
    logic        guardHit_q, guardHit_d;
    logic        status_q, status_d;
    logic [18:0] progCnt_q, progCnt_d;
    logic [2:0]  tsvCnt_q, tsvCnt_d;
    logic        ready_q, ready_d;
    logic        do_q, do_d;
    logic        doOe_q, doOe_d;
    logic [15:0] rdWord;
    logic        busyStart;

    assign rdWord = mem[addr_q];

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        hdr_d      = hdr_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        rdPtr_d    = rdPtr_q;
        unlocked_d = unlocked_q;
        guardHit_d = guardHit_q;
        status_d   = status_q;
        progCnt_d  = progCnt_q;
        tsvCnt_d   = tsvCnt_q;
        ready_d    = ready_q;
        do_d       = do_q;
        doOe_d     = doOe_q;
        memWe      = 1'b0;
        busyStart  = 1'b0;
        // busy indication goes low a fixed delay after the start
        if (tsvCnt_q != 3'h0) begin
            tsvCnt_d = tsvCnt_q - 3'h1;
            if (tsvCnt_q == 3'h1) begin
                ready_d = 1'b0;
            end
        end
        if (state_q == swep_pkg::ST_BUSY) begin
            // timer runs on mclk, so the serial clock level is free
            progCnt_d = progCnt_q - 19'h1;
            if (guardS) begin
                // halted word is left as it was: contents not trusted
                ready_d  = 1'b1;
                tsvCnt_d = 3'h0;
                state_d  = selS ? swep_pkg::ST_FRAME
                                : swep_pkg::ST_IGNORE;
            end else if (progCnt_q == 19'h0) begin
                memWe    = 1'b1;
                ready_d  = 1'b1;
                tsvCnt_d = 3'h0;
                state_d  = selS ? swep_pkg::ST_FRAME
                                : swep_pkg::ST_IGNORE;
            end
        end
        if (csFall && !skS && state_q == swep_pkg::ST_BUSY) begin
            status_d = 1'b1;
            doOe_d   = 1'b1;
        end
        if (status_q && !selS) begin
            do_d = ready_q;
        end
        if (csRise) begin
            status_d = 1'b0;
            doOe_d   = 1'b0;
            cnt_d    = 6'h0;
            // a pending write dies here with nothing stored
            if (state_q != swep_pkg::ST_BUSY) begin
                state_d = swep_pkg::ST_FRAME;
            end
        end else if (skRise) begin
            case (state_q)
                swep_pkg::ST_FRAME: begin
                    cnt_d = cnt_q + 6'h1;
                    if (cnt_q <= swep_pkg::CNT_HDR) begin
                        hdr_d = {hdr_q[6:0], sinS};
                    end else begin
                        addr_d[cnt_q[2:0]] = sinS;
                    end
                    if (cnt_q == swep_pkg::CNT_HDR
                        && !hdrOk({hdr_q[6:0], sinS})) begin
                        state_d = swep_pkg::ST_IGNORE;
                    end
                    if (cnt_q == swep_pkg::CNT_ADDR) begin
                        // guard level not looked at for lock and unlock
                        case (hdr_q[3:0])
                            swep_pkg::OP_UNLOCK: begin
                                unlocked_d = 1'b1;
                                state_d    = swep_pkg::ST_IGNORE;
                            end
                            swep_pkg::OP_LOCK: begin
                                unlocked_d = 1'b0;
                                state_d    = swep_pkg::ST_IGNORE;
                            end
                            swep_pkg::OP_READ: begin
                                rdPtr_d = 4'h0;
                                state_d = swep_pkg::ST_READ;
                            end
                            default: begin
                                guardHit_d = guardS;
                                state_d    = swep_pkg::ST_WRITE;
                            end
                        endcase
                    end
                end
                swep_pkg::ST_WRITE: begin
                    cnt_d = cnt_q + 6'h1;
                    wdata_d[cnt_q[3:0]] = sinS;
                    if (guardS) begin
                        guardHit_d = 1'b1;
                    end
                    if (cnt_q == swep_pkg::CNT_DATA) begin
                        if (unlocked_q && !guardHit_q && !guardS) begin
                            busyStart = 1'b1;
                            progCnt_d = 19'(PROG_CYCLES - 1);
                            tsvCnt_d  = 3'(swep_pkg::STATUS_CYC);
                            state_d   = swep_pkg::ST_BUSY;
                        end else begin
                            state_d = swep_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (skFall && state_q == swep_pkg::ST_READ) begin
            do_d    = rdWord[rdPtr_q];
            doOe_d  = 1'b1;
            rdPtr_d = rdPtr_q + 4'h1;
            if (rdPtr_q == 4'hf) begin
                addr_d = addr_q + 8'h1;
            end
        end
        if (state_q == swep_pkg::ST_WRITE && guardS) begin
            guardHit_d = 1'b1;
        end
    end

    // start pattern and known opcode, bits in arrival order
    function automatic logic hdrOk(input logic [7:0] h);
        hdrOk = (h[7:4] == swep_pkg::START_PAT)
              && (h[3:0] == swep_pkg::OP_READ
                  || h[3:0] == swep_pkg::OP_WRITE
                  || h[3:0] == swep_pkg::OP_UNLOCK
                  || h[3:0] == swep_pkg::OP_LOCK);
    endfunction : hdrOk

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q    <= swep_pkg::ST_FRAME;
            cnt_q      <= 6'h0;
            hdr_q      <= 8'h0;
            addr_q     <= 8'h0;
            wdata_q    <= 16'h0;
            rdPtr_q    <= 4'h0;
            unlocked_q <= 1'b0;
            guardHit_q <= 1'b0;
            status_q   <= 1'b0;
            progCnt_q  <= 19'h0;
            tsvCnt_q   <= 3'h0;
            ready_q    <= 1'b1;
            do_q       <= 1'b0;
            doOe_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            hdr_q      <= hdr_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            rdPtr_q    <= rdPtr_d;
            unlocked_q <= unlocked_d;
            guardHit_q <= guardHit_d;
            status_q   <= status_d;
            progCnt_q  <= progCnt_d;
            tsvCnt_q   <= tsvCnt_d;
            ready_q    <= ready_d;
            do_q       <= do_d;
            doOe_q     <= doOe_d;
        end
    end

    assign serialOut   = do_q;
    assign serialOutOe = doOe_q;
    assign readyBusyN  = ready_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence busyLowSeq;
        ready_q [*6] ##1 !ready_q;
    endsequence

    locked_write_a: assert property (
        state_q == swep_pkg::ST_WRITE && skRise && !csRise
        && cnt_q == swep_pkg::CNT_DATA && !unlocked_q
        |=> state_q == swep_pkg::ST_IGNORE && ready_q)
        else $error("write accepted while locked");
    busy_delay_a: assert property (
        busyStart |-> ##1 busyLowSeq)
        else $error("busy status delay wrong");
    read_first_a: assert property (
        state_q == swep_pkg::ST_READ && skFall && !csRise
        && rdPtr_q == 4'h0 |=> do_q == $past(rdWord[0]) && doOe_q)
        else $error("read did not start with bit zero");
    read_next_a: assert property (
        state_q == swep_pkg::ST_READ && skFall && !csRise
        && rdPtr_q == 4'hf |=> addr_q == $past(addr_q) + 8'h1)
        else $error("read address did not advance");
    ignore_hold_a: assert property (
        state_q == swep_pkg::ST_IGNORE && !selS && !csRise
        |=> state_q == swep_pkg::ST_IGNORE)
        else $error("input taken before select rose");
    cs_cancel_a: assert property (
        csRise && state_q != swep_pkg::ST_BUSY
        |=> state_q == swep_pkg::ST_FRAME && !doOe_q && cnt_q == 6'h0)
        else $error("select rise did not reset interface");
    guard_halt_a: assert property (
        state_q == swep_pkg::ST_BUSY && guardS
        |-> !memWe ##1 state_q != swep_pkg::ST_BUSY && ready_q)
        else $error("programming not halted by guard");
    busy_hold_a: assert property (
        state_q == swep_pkg::ST_BUSY && progCnt_q != 19'h0 && !guardS
        |=> state_q == swep_pkg::ST_BUSY)
        else $error("busy state left early");
    unlock_cmd_a: assert property (
        state_q == swep_pkg::ST_FRAME && skRise && !csRise
        && cnt_q == swep_pkg::CNT_ADDR && hdr_q[3:0] == swep_pkg::OP_UNLOCK
        |=> unlocked_q && state_q == swep_pkg::ST_IGNORE)
        else $error("unlock not applied");
    idle_stable_a: assert property (
        selS && selPrev_q && state_q == swep_pkg::ST_FRAME
        |=> $stable(cnt_q))
        else $error("frame advanced while deselected");
endmodule : swep_core

/* File: verif/swep_host_model.sv */
// host-side model that drives the serial link of the memory
module swep_host_model (
    input  wire logic mclk,
    input  wire logic serialOut,
    output logic      selectN,
    output logic      serialClk,
    output logic      serialData,
    output logic      writeGuard
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        selectN    = 1'b1;
        serialClk  = 1'b0;
        serialData = 1'b0;
        writeGuard = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask : ticks

    task automatic set_guard(input logic v);
        @(negedge mclk);
        writeGuard = v;
    endtask : set_guard

    // ends any frame; data line left at a changed level so no stale bit
    task automatic release_select();
        ticks(2);
        selectN    = 1'b1;
        serialData = ~serialData;
        ticks(6);
    endtask : release_select

    // ------------------------------------------------------------
    // one frame; guardBit pulses the guard for one bit, 99 for none
    // ------------------------------------------------------------
    task automatic frame(input logic [3:0] op, input logic [7:0] addr,
                         input logic [15:0] data, input int nBits,
                         input int guardBit, output logic [31:0] cap);
        logic b;
        int   i;
        cap = 32'h0000_0000;
        @(negedge mclk);
        selectN = 1'b0;
        ticks(3);
        for (i = 0; i < nBits; i++) begin
            if (i < 4) begin
                b = swep_pkg::START_PAT[3-i];
            end else if (i < 8) begin
                b = op[7-i];
            end else if (i < 16) begin
                b = addr[i-8];
            end else begin
                b = data[(i-16)%16];
            end
            serialClk  = 1'b0;
            // reply phase of a read: line left alone for a tied bus
            if (i < 16 || op != swep_pkg::OP_READ) begin
                serialData = b;
            end
            if (i == guardBit) begin
                writeGuard = 1'b1;
            end else if (i == guardBit + 1) begin
                writeGuard = 1'b0;
            end
            ticks(4);
            serialClk = 1'b1;
            ticks(4);
            // sampled just before the next falling edge
            if (i >= 16 && i < 48) begin
                cap[i-16] = serialOut;
            end
        end
        serialClk = 1'b0;
        ticks(4);
    endtask : frame
endmodule : swep_host_model

/* File: verif/tb_serial_word_eeprom_protocol.sv */
// self-checking bench for the serial word memory protocol block
module tb_serial_word_eeprom_protocol;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PROG = 1000;
    logic        mclk;
    logic        reset;
    logic        selectN;
    logic        serialClk;
    logic        serialData;
    logic        writeGuard;
    logic        serialOut;
    logic        serialOutOe;
    logic        readyBusyN;
    logic [31:0] cap;
    int          numErrors;
    int          nTests;
    int          n;
    logic        lineIn;

    // released output floats to its pull-up level
    assign lineIn = serialOutOe ? serialOut : 1'b1;

    swep_core #(.PROG_CYCLES(PROG)) dut (
        .mclk(mclk), .reset(reset), .selectN(selectN),
        .serial_clock_in(serialClk), .serial_in(serialData),
        .write_guard_pin(writeGuard), .serialOut(serialOut),
        .serialOutOe(serialOutOe), .readyBusyN(readyBusyN));

    swep_host_model host (
        .mclk(mclk), .serialOut(lineIn), .selectN(selectN),
        .serialClk(serialClk), .serialData(serialData),
        .writeGuard(writeGuard));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (numErrors == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk1(input string what, input logic e, input logic g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask : chk1

    task automatic chk16(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk16

    task automatic wait_rb(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (readyBusyN !== v && cnt < lim) begin
            @(negedge mclk);
            cnt++;
        end
        chk1("ready/busy level", v, readyBusyN);
    endtask : wait_rb

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.frame(swep_pkg::OP_READ, a, 16'h0000, 32, 99, cap);
        host.release_select();
        chk16("read word", e, cap[15:0]);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.frame(swep_pkg::OP_WRITE, a, d, 32, 99, cap);
        wait_rb(1'b0, 16, n);
        chk1("busy after write", 1'b0, readyBusyN);
        host.release_select();
        wait_rb(1'b1, PROG + 50, n);
    endtask : wr

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_locked();
        host.frame(swep_pkg::OP_WRITE, 8'h05, 16'h1234, 32, 99, cap);
        host.release_select();
        host.ticks(20);
        chk1("locked write busy", 1'b1, readyBusyN);
        rd(8'h05, swep_pkg::ERASED);
    endtask : t_locked

    task automatic t_unlock_write();
        host.set_guard(1'b1);
        // extra clocks past the sixteenth, guard high throughout
        host.frame(swep_pkg::OP_UNLOCK, 8'h5a, 16'hffff, 24, 99, cap);
        host.set_guard(1'b0);
        host.release_select();
        host.frame(swep_pkg::OP_WRITE, 8'h05, 16'h1234, 32, 99, cap);
        wait_rb(1'b0, 16, n);
        chk1("busy after write", 1'b0, readyBusyN);
        wait_rb(1'b1, PROG + 50, n);
        chk1("busy length", 1'b1, n >= PROG - 8 && n <= PROG);
        host.release_select();
        rd(8'h05, 16'h1234);
    endtask : t_unlock_write

    task automatic t_seq_read();
        wr(8'h06, 16'h5678);
        host.frame(swep_pkg::OP_READ, 8'h05, 16'h0000, 48, 99, cap);
        chk16("first word", 16'h1234, cap[15:0]);
        chk16("next word", 16'h5678, cap[31:16]);
        host.release_select();
        chk1("oe after select", 1'b0, serialOutOe);
    endtask : t_seq_read

    task automatic t_busy_status();
        wr(8'h07, 16'h9abc);
        host.frame(swep_pkg::OP_WRITE, 8'h07, 16'h9abc, 32, 99, cap);
        wait_rb(1'b0, 16, n);
        host.release_select();
        // a read tried while busy only shows the low status
        host.frame(swep_pkg::OP_READ, 8'h05, 16'h0000, 32, 99, cap);
        chk1("status oe", 1'b1, serialOutOe);
        chk16("status bits", 16'h0000, cap[15:0]);
        wait_rb(1'b1, PROG + 50, n);
        host.ticks(2);
        chk1("ready status", 1'b1, serialOut);
        host.release_select();
        rd(8'h07, 16'h9abc);
    endtask : t_busy_status

    task automatic t_cancel();
        host.frame(swep_pkg::OP_WRITE, 8'h05, 16'hdead, 20, 99, cap);
        host.release_select();
        host.ticks(20);
        chk1("cut write busy", 1'b1, readyBusyN);
        host.frame(swep_pkg::OP_WRITE, 8'h05, 16'hbeef, 32, 24, cap);
        host.release_select();
        host.ticks(20);
        chk1("guarded write busy", 1'b1, readyBusyN);
        rd(8'h05, 16'h1234);
    endtask : t_cancel

    task automatic t_guard_halt();
        wr(8'h06, 16'h0f0f);
        host.frame(swep_pkg::OP_WRITE, 8'h06, 16'hf0f0, 32, 99, cap);
        wait_rb(1'b0, 16, n);
        host.release_select();
        host.set_guard(1'b1);
        host.ticks(8);
        host.set_guard(1'b0);
        wait_rb(1'b1, PROG + 50, n);
        rd(8'h06, 16'h0f0f);
    endtask : t_guard_halt

    task automatic t_ignore_after_ready();
        host.frame(swep_pkg::OP_WRITE, 8'h08, 16'h1111, 32, 99, cap);
        wait_rb(1'b0, 16, n);
        wait_rb(1'b1, PROG + 50, n);
        // select never raised, so this read must go unheard
        host.frame(swep_pkg::OP_READ, 8'h08, 16'h0000, 32, 99, cap);
        chk1("oe without toggle", 1'b0, serialOutOe);
        chk16("idle line", 16'hffff, cap[15:0]);
        host.release_select();
        rd(8'h08, 16'h1111);
    endtask : t_ignore_after_ready

    task automatic t_lock();
        host.frame(swep_pkg::OP_LOCK, 8'h00, 16'h0000, 16, 99, cap);
        host.release_select();
        host.frame(swep_pkg::OP_WRITE, 8'h09, 16'h2222, 32, 99, cap);
        host.release_select();
        host.ticks(20);
        chk1("relocked busy", 1'b1, readyBusyN);
        rd(8'h09, swep_pkg::ERASED);
    endtask : t_lock

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        numErrors = 0;
        nTests    = 0;
        reset     = 1'b1;
        repeat (6) @(negedge mclk);
        // reset stands in for power; it is never cut before the end
        reset = 1'b0;
        host.ticks(4);
        t_locked();
        t_unlock_write();
        t_seq_read();
        t_busy_status();
        t_cancel();
        t_guard_halt();
        t_ignore_after_ready();
        t_lock();
        wrap_up();
    end

    // about three times the expected length of the sequence
    initial begin
        repeat (40000) @(posedge mclk);
        numErrors++;
        wrap_up();
    end
endmodule : tb_serial_word_eeprom_protocol
